// [jdt_jtag_model.sv]
// Behavioural outside test controller: drives test clock, mode select, serial in.
// Assumes the chain answers on falling test clock; the clock stands still between frames.
`timescale 1ns/1ps
module jdt_jtag_model
  import jdt_pkg::*;
(
  output logic o_tck, // Test clock, low between frames
  output logic o_tms, // Mode select, released high
  output logic o_tdi, // Serial data, released high
  input wire logic i_tdo, // Serial data back from chain
  input wire logic i_tdo_oe_n // Low while serial out driven
);
  localparam int HALF = 16;

  // Lines start released, pull-ups hold them high
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // ----------------------------------------------------------------
  // Line handling
  // ----------------------------------------------------------------
  // sample before rise
  task automatic cycle(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    o_tms = tms;
    o_tdi = tdi;
    #HALF;
    tdo = i_tdo_oe_n ? ~i_tdo : i_tdo; // No pull-up here, a released line reads wrong
    oe_n = i_tdo_oe_n;
    o_tck = 1'b1;
    #HALF;
    o_tck = 1'b0;
  endtask

  // Released lines float to the pull-up level
  task automatic release_lines();
    o_tms = 1'b1;
    o_tdi = 1'b1;
  endtask

  task automatic step(input logic tms);
    logic t, e;
    cycle(tms, 1'b1, t, e);
  endtask

  task automatic reset5();
    repeat (RESET_TMS_EDGES) step(1'b1);
    step(1'b0); // Park in idle
    release_lines();
  endtask

  // ----------------------------------------------------------------
  // Full scan from idle back to idle
  // ----------------------------------------------------------------
  // instruction loads carry 11 bits
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic all_oe);
    logic t, e;
    dout = '0;
    all_oe = 1'b1;
    step(1'b1);
    if (ir) begin
      step(1'b1);
    end
    step(1'b0); // Capture
    step(1'b0); // Into shift
    for (int i = 0; i < n; i++) begin
      cycle(i == n - 1, din[i], t, e);
      dout[i] = t;
      all_oe &= ~e; // Must stay driven on every shifted bit
    end
    step(1'b1); // Update
    step(1'b0); // Idle
    release_lines();
  endtask
endmodule

// [jdt_pkg.sv]
// Shared constants and types for the two-controller boundary-scan chain.
// Assumes one system clock plus the test clock from the outside test controller.
package jdt_pkg;

  // ----------------------------------------------------------------
  // Register sizes
  // ----------------------------------------------------------------
  localparam int IR1_W = 3;
  localparam int IR2_W = 8;
  localparam int ID_W = 32;
  localparam int N_IN = 8;
  localparam int N_OUT = 8;
  localparam int N_NC = 2;
  localparam int BSR_W = N_IN + N_OUT + N_NC;

  // ----------------------------------------------------------------
  // Opcodes, capture values and reset count
  // ----------------------------------------------------------------
  localparam logic [IR1_W-1:0] OP1_BYPASS = 3'h7;
  localparam logic [IR1_W-1:0] IR1_CAPTURE = 3'h1;
  localparam logic [IR2_W-1:0] OP2_BYPASS = 8'hFF;
  localparam logic [IR2_W-1:0] OP2_EXTEST = 8'h00;
  localparam logic [IR2_W-1:0] OP2_HIGHZ = 8'h07;
  localparam logic [IR2_W-1:0] OP2_IDCODE = 8'h0F;
  localparam logic [IR2_W-1:0] OP2_SAMPLE = 8'h01;
  localparam logic [IR2_W-1:0] IR2_CAPTURE = 8'h01;
  // Identification value is arbitrary, chosen for this design
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C0001;
  localparam int RESET_TMS_EDGES = 5;

  // ----------------------------------------------------------------
  // Controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR  = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR  = 16'h8000
  } jdt_tap_st_t;

  // Data register chosen in the second controller
  typedef enum logic [2:0] {
    SEL_BYP = 3'h1,
    SEL_ID  = 3'h2,
    SEL_BSR = 3'h4
  } jdt_sel_t;

  // Pin control word passed from test clock to system clock
  typedef struct packed {
    logic extest;
    logic highz;
    logic [N_OUT-1:0] drive;
  } jdt_pin_word_t;

endpackage

// [jdt_tap_top.sv]
// Two test access controllers chained behind one set of test pins, with the
// boundary cells of the device pins. Assumes the test clock is free of the
// system clock and may stop between scans; the system clock runs freely.
//
// What this block does
// RULE1: Sample test inputs on rising test clock, change outputs on falling edge.
// RULE2: Serial input enters register MSB; serial output leaves from its LSB.
// RULE3: Serial output driven only while shifting; otherwise released.
// RULE4: Five rising edges with mode select high reset the controller.
// RULE5: Exactly one register in the path, chosen by current instruction.
// RULE6: First controller 3-bit instruction, second 8-bit; each a 1-bit bypass.
// RULE7: Reset state loads the identification instruction; the first controller loads its bypass 111 instead.
// RULE8: Bypass path is one flip-flop, one stage of delay.
// RULE9: Capture loads all pin cells, unconnected included; shift moves them.
// RULE10: Identification captures fixed 32-bit code and shifts it out.
// RULE11: Opcodes: bypass FF, highz 07, ident 0F, sample 01; first bypass 111.
// RULE12: Sample snapshots pins; shifting out and preloading happen together.
// RULE13: Preload puts shifted pattern onto latched parallel cell outputs.
// RULE14: Bypass instruction in shift puts only bypass bit in path.
// RULE15: High impedance releases all user pins; bypass bit is selected.
// RULE16: External test drives preloaded values; boundary register in the path.
// RULE17: Tester shifts 11 instruction bits: 111 then the 8-bit code.
// RULE18: Both in bypass gives two test-clock delay from input to output.
// RULE19: Each controller is a 16-state machine stepped by mode select.
// RULE20: Controllers share clock and mode select; chained into one path.
// RULE21: Transitions follow the standard sixteen-state diagram.
// RULE22: External test opcode of second controller is all zeros.
// RULE23: Unlisted opcodes of second controller act as bypass.
`timescale 1ns/1ps
module jdt_tap_top
  import jdt_pkg::*;
(
  input wire logic i_clock, // System clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic i_tck, // Test clock
  input wire logic i_tms, // Test mode select
  input wire logic i_tdi, // Test serial data in
  input wire logic [N_IN-1:0] i_pin_in, // Device input pins
  input wire logic [N_OUT-1:0] i_core_out, // Core values for output pins
  input wire logic [N_OUT-1:0] i_core_oe_n, // Core enables, low drives
  output logic o_tdo, // Test serial data out
  output logic o_tdo_oe_n, // Low while serial out is driven
  output logic [N_OUT-1:0] o_pin_out, // Output pin values
  output logic [N_OUT-1:0] o_pin_oe_n // Output pin enables, low drives
);

  // ----------------------------------------------------------------
  // Test clock reset
  // ----------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic tck_rst;

  // Stands in for power-up; only the second stage is read
  always_ff @(posedge i_tck) begin
    rst_s1_ff <= i_srst;
    rst_s2_ff <= rst_s1_ff;
  end
  assign tck_rst = rst_s2_ff;

  // ----------------------------------------------------------------
  // Controller state machines
  // ----------------------------------------------------------------
  function automatic jdt_tap_st_t tap_next(input jdt_tap_st_t st, input logic tms);
    jdt_tap_st_t nx;
    nx = ST_RESET;
    unique case (st)
      ST_RESET: nx = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: nx = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nx = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nx = tms ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: nx = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nx = tms ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: nx = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nx = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nx = tms ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: nx = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nx = tms ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR: nx = tms ? ST_SEL_DR : ST_IDLE;
      default: nx = ST_RESET;
    endcase
    return nx;
  endfunction

  // RULE19 RULE20 RULE21: two machines, shared clock and select
  for (genvar g = 0; g < 2; g++) begin : tap_g
    jdt_tap_st_t st_ff;
    // RULE1 RULE4: step on rising edge
    always_ff @(posedge i_tck) begin
      if (tck_rst) begin
        st_ff <= ST_RESET;
      end else begin
        st_ff <= tap_next(st_ff, i_tms);
      end
    end
  end

  jdt_tap_st_t st1;
  jdt_tap_st_t st2;
  assign st1 = tap_g[0].st_ff;
  assign st2 = tap_g[1].st_ff;

  // ----------------------------------------------------------------
  // Instruction registers
  // ----------------------------------------------------------------
  logic [IR1_W-1:0] ir1_sr_ff;
  logic [IR1_W-1:0] ir1_ff;
  logic [IR2_W-1:0] ir2_sr_ff;
  logic [IR2_W-1:0] ir2_ff;
  logic [IR2_W-1:0] nxt_ir2;
  logic tap2_out;

  // RULE2 RULE6: first instruction shifter, fed from second controller
  always_ff @(posedge i_tck) begin
    if (st1 == ST_CAP_IR) begin
      ir1_sr_ff <= IR1_CAPTURE;
    end else if (st1 == ST_SH_IR) begin
      ir1_sr_ff <= {tap2_out, ir1_sr_ff[IR1_W-1:1]};
    end
  end

  // RULE7: reset holds the only supported instruction of the first
  always_ff @(posedge i_tck) begin
    if (tck_rst || st1 == ST_RESET) begin
      ir1_ff <= OP1_BYPASS;
    end else if (st1 == ST_UP_IR) begin
      ir1_ff <= ir1_sr_ff;
    end
  end

  // RULE2 RULE6: second instruction shifter, fed from serial input
  always_ff @(posedge i_tck) begin
    if (st2 == ST_CAP_IR) begin
      ir2_sr_ff <= IR2_CAPTURE;
    end else if (st2 == ST_SH_IR) begin
      ir2_sr_ff <= {i_tdi, ir2_sr_ff[IR2_W-1:1]};
    end
  end

  // RULE7: reset state reloads identification
  always_comb begin
    if (tck_rst || st2 == ST_RESET) begin
      nxt_ir2 = OP2_IDCODE;
    end else if (st2 == ST_UP_IR) begin
      nxt_ir2 = ir2_sr_ff;
    end else begin
      nxt_ir2 = ir2_ff;
    end
  end
  // Next value also feeds the pin word, so a stopped test clock still hands it over
  always_ff @(posedge i_tck) begin
    ir2_ff <= nxt_ir2;
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  jdt_sel_t sel2;
  logic bsr_op;
  logic extest_op;
  logic highz_op;

  // RULE11 RULE22 RULE23: opcode decode, unknown codes bypass
  always_comb begin
    unique case (ir2_ff)
      OP2_EXTEST, OP2_SAMPLE: sel2 = SEL_BSR;
      OP2_IDCODE: sel2 = SEL_ID;
      default: sel2 = SEL_BYP;
    endcase
  end
  assign bsr_op = (sel2 == SEL_BSR);
  assign extest_op = (nxt_ir2 == OP2_EXTEST);
  // RULE15: high impedance keeps the bypass bit selected
  assign highz_op = (nxt_ir2 == OP2_HIGHZ);

  // ----------------------------------------------------------------
  // Data registers of the second controller
  // ----------------------------------------------------------------
  logic byp2_ff;
  logic [ID_W-1:0] id_sr_ff;
  logic [BSR_W-1:0] bsr_ff;
  logic [BSR_W-1:0] upd_ff;
  logic [N_IN+N_OUT-1:0] cap_s1_ff;
  logic [N_IN+N_OUT-1:0] cap_s2_ff;
  logic [BSR_W-1:0] cap_vec;

  // RULE8 RULE14: single bypass stage
  always_ff @(posedge i_tck) begin
    if (st2 == ST_CAP_DR) begin
      byp2_ff <= 1'b0;
    end else if (st2 == ST_SH_DR && sel2 == SEL_BYP) begin
      byp2_ff <= i_tdi;
    end
  end

  // RULE10: fixed code captured then shifted
  always_ff @(posedge i_tck) begin
    if (st2 == ST_CAP_DR && sel2 == SEL_ID) begin
      id_sr_ff <= ID_VALUE;
    end else if (st2 == ST_SH_DR && sel2 == SEL_ID) begin
      id_sr_ff <= {i_tdi, id_sr_ff[ID_W-1:1]};
    end
  end

  // Pin levels come from other domains, so two stages first
  always_ff @(posedge i_tck) begin
    cap_s1_ff <= {i_pin_in, o_pin_out};
    cap_s2_ff <= cap_s1_ff;
  end
  // Unconnected cells capture zero
  assign cap_vec = {{N_NC{1'b0}}, cap_s2_ff};

  // RULE9 RULE12: capture all cells, shift captured out as new data in
  always_ff @(posedge i_tck) begin
    if (st2 == ST_CAP_DR && bsr_op) begin
      bsr_ff <= cap_vec;
    end else if (st2 == ST_SH_DR && bsr_op) begin
      bsr_ff <= {i_tdi, bsr_ff[BSR_W-1:1]};
    end
  end

  // RULE13: latched parallel outputs take the preload pattern
  always_ff @(posedge i_tck) begin
    if (tck_rst) begin
      upd_ff <= '0;
    end else if (st2 == ST_UP_DR && bsr_op) begin
      upd_ff <= bsr_ff;
    end
  end

  // RULE5 RULE20: second controller output by current selection
  always_comb begin
    if (st2 == ST_SH_IR) begin
      tap2_out = ir2_sr_ff[0];
    end else begin
      unique case (sel2)
        SEL_ID: tap2_out = id_sr_ff[0];
        SEL_BSR: tap2_out = bsr_ff[0];
        default: tap2_out = byp2_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // First controller and serial output
  // ----------------------------------------------------------------
  logic byp1_ff;
  logic tap1_out;
  logic shifting;

  // RULE8 RULE18 RULE20: bypass stage fed by the second controller
  always_ff @(posedge i_tck) begin
    if (st1 == ST_CAP_DR) begin
      byp1_ff <= 1'b0;
    end else if (st1 == ST_SH_DR) begin
      byp1_ff <= tap2_out;
    end
  end

  // RULE2 RULE5: least significant bit of the selected register
  assign tap1_out = (st1 == ST_SH_IR) ? ir1_sr_ff[0] : byp1_ff;
  assign shifting = (st1 == ST_SH_DR) || (st1 == ST_SH_IR);

  // RULE1 RULE3: change on falling edge, released when not shifting
  always_ff @(negedge i_tck) begin
    if (tck_rst) begin
      o_tdo <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end else begin
      o_tdo <= tap1_out;
      o_tdo_oe_n <= !shifting;
    end
  end

  // ----------------------------------------------------------------
  // Pin control crossing to the system clock
  // ----------------------------------------------------------------
  jdt_pin_word_t nxt_word;
  jdt_pin_word_t xfer_word_ff;
  logic xfer_tgl_ff;

  // Built from next values so the word leaves on the update edge itself
  assign nxt_word = '{extest: extest_op, highz: highz_op,
    drive: (st2 == ST_UP_DR && bsr_op) ? bsr_ff[N_OUT-1:0] : upd_ff[N_OUT-1:0]};

  // Word held steady, toggle announces each change
  always_ff @(posedge i_tck) begin
    if (tck_rst) begin
      xfer_word_ff <= '0;
      xfer_tgl_ff <= 1'b0;
    end else if (nxt_word != xfer_word_ff) begin
      xfer_word_ff <= nxt_word;
      xfer_tgl_ff <= !xfer_tgl_ff;
    end
  end

  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  jdt_pin_word_t sys_word_ff;

  // Word is stable for many system cycles after a toggle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      sys_word_ff <= '0;
    end else begin
      tgl_s1_ff <= xfer_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      if (tgl_s2_ff != tgl_s3_ff) begin
        sys_word_ff <= xfer_word_ff;
      end
    end
  end

  // RULE15 RULE16: pin drive, high impedance first
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pin_out <= '0;
      o_pin_oe_n <= '1;
    end else if (sys_word_ff.highz) begin
      o_pin_out <= i_core_out;
      o_pin_oe_n <= '1;
    end else if (sys_word_ff.extest) begin
      o_pin_out <= sys_word_ff.drive;
      o_pin_oe_n <= '0;
    end else begin
      o_pin_out <= i_core_out;
      o_pin_oe_n <= i_core_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence tms_five_s;
    i_tms [*5];
  endsequence

  sequence both_bypass_shift_s;
    (st1 == ST_SH_DR && sel2 == SEL_BYP && ir1_ff == OP1_BYPASS) [*3];
  endsequence

  AST_TMS_RESET: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE4
    tms_five_s |=> (st1 == ST_RESET && st2 == ST_RESET))
    else $error("five high mode selects did not reset");

  AST_IR_IDCODE: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE7
    st2 == ST_RESET |=> ir2_ff == OP2_IDCODE && ir1_ff == OP1_BYPASS)
    else $error("reset state did not load identification");

  AST_TDO_ENABLE: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE3
    $past(!tck_rst) |-> o_tdo_oe_n == !shifting)
    else $error("serial out enable not tied to shifting");

  AST_TWO_DELAY: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE18
    both_bypass_shift_s |-> o_tdo == $past(i_tdi, 2))
    else $error("bypass chain delay is not two cycles");

  AST_ID_CAPTURE: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE10
    (st2 == ST_CAP_DR && ir2_ff == OP2_IDCODE) |=> id_sr_ff == ID_VALUE)
    else $error("identification code not captured");

  AST_BSR_CAPTURE: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE9
    (st2 == ST_CAP_DR && bsr_op) |=> bsr_ff == $past(cap_vec))
    else $error("boundary cells not captured");

  AST_BSR_SHIFT: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE2
    (st2 == ST_SH_DR && bsr_op) |=> bsr_ff == {$past(i_tdi), $past(bsr_ff[BSR_W-1:1])})
    else $error("boundary shift direction wrong");

  AST_PRELOAD: assert property (@(posedge i_tck) disable iff (tck_rst) // RULE13
    (st2 == ST_UP_DR && bsr_op) |=> upd_ff == $past(bsr_ff))
    else $error("preload pattern not latched");

  AST_HIGHZ_PINS: assert property (@(posedge i_clock) disable iff (i_srst) // RULE15
    sys_word_ff.highz |=> o_pin_oe_n == '1)
    else $error("pins driven under high impedance");

  AST_EXTEST_DRIVE: assert property (@(posedge i_clock) disable iff (i_srst) // RULE16
    (sys_word_ff.extest && !sys_word_ff.highz) |=> (o_pin_oe_n == '0 && o_pin_out == $past(sys_word_ff.drive)))
    else $error("external test values not driven");

endmodule

// [jdt_tap_top_tb.sv]
// Self-checking bench for the chained boundary-scan port.
// Assumes the controller model makes the test clock; pins driven on falling system clock.
`timescale 1ns/1ps
module jdt_tap_top_tb
  import jdt_pkg::*;
;
  logic i_clock, i_srst, tck, tms, tdi, o_tdo, o_tdo_oe_n;
  logic [N_IN-1:0] pin_in;
  logic [N_OUT-1:0] core_out, core_oe_n, o_pin_out, o_pin_oe_n;
  logic [63:0] dout;
  logic all_oe;
  int failures = 0;
  int n_checks = 0;

  jdt_tap_top dut (.i_clock(i_clock), .i_srst(i_srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_pin_in(pin_in), .i_core_out(core_out), .i_core_oe_n(core_oe_n), .o_tdo(o_tdo),
    .o_tdo_oe_n(o_tdo_oe_n), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));
  jdt_jtag_model ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n));

  // System clock, 8 ns
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Long enough for the pin word to cross; sample off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic ir_load(input logic [IR2_W-1:0] op);
    ctl.scan(1'b1, 11, 64'({op, OP1_BYPASS}), dout, all_oe);
    check(64'(dout[10:0]), 64'({IR2_CAPTURE, IR1_CAPTURE}));
    check(64'(all_oe), 64'h1);
    #1; // Let the falling-edge update land first
    check(64'(o_tdo_oe_n), 64'h1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idcode();
    ctl.scan(1'b0, 33, 64'h1_F0F0_3C3C, dout, all_oe);
    check(64'(dout[0]), 64'h0);
    check(64'(dout[32:1]), 64'(ID_VALUE));
    check(64'(all_oe), 64'h1);
  endtask

  task automatic t_bypass_kinds();
    logic [IR2_W-1:0] ops [3];
    logic [19:0] din;
    ops = '{OP2_BYPASS, OP2_HIGHZ, 8'h55};
    din = 20'hB3C5A;
    foreach (ops[k]) begin
      ir_load(ops[k]);
      ctl.scan(1'b0, 20, 64'(din), dout, all_oe);
      check(64'(dout[19:0]), 64'({din[17:0], 2'b00}));
      check(64'(dout[19:0]), 64'({din[17:0], 2'b00}));
      wait_clk(20);
      check(64'(o_pin_oe_n), (ops[k] == OP2_HIGHZ) ? 64'hFF : 64'(core_oe_n));
    end
  endtask

  task automatic t_sample_extest();
    logic [BSR_W-1:0] pat;
    pat = 18'h1B4C6;
    ir_load(OP2_SAMPLE);
    ctl.scan(1'b0, 19, 64'({pat, 1'b1}), dout, all_oe);
    check(64'(dout[18:0]), 64'({2'b00, pin_in, core_out, 1'b0}));
    ir_load(OP2_EXTEST);
    @(negedge i_clock);
    core_out = 8'h81; // Core values must be ignored now
    wait_clk(20);
    check(64'(o_pin_out), 64'(pat[7:0]));
    check(64'(o_pin_oe_n), 64'h00);
    ctl.scan(1'b0, 19, 64'({pat, 1'b1}), dout, all_oe);
    check(64'(dout[18:1]), 64'({2'b00, pin_in, pat[7:0]}));
  endtask

  task automatic t_tms_reset();
    ctl.step(1'b1);
    ctl.step(1'b1);
    ctl.step(1'b0);
    ctl.step(1'b0); // Left parked in instruction shift
    ctl.reset5();
    wait_clk(20);
    check(64'(o_pin_out), 64'(core_out));
    check(64'(o_pin_oe_n), 64'(core_oe_n));
    t_idcode();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Reset held over several test clocks so the test side clears too
  initial begin
    i_srst = 1'b1;
    pin_in = 8'hA5;
    core_out = 8'h3C;
    core_oe_n = 8'h00;
    ctl.reset5();
    @(negedge i_clock);
    i_srst = 1'b0;
    ctl.reset5();
    wait_clk(4);
    t_idcode();
    t_bypass_kinds();
    t_sample_extest();
    t_tms_reset();
    end_sim();
  end

  // Watchdog, far beyond the expected run of under 40 us
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
